/* pkg/hgp_defines.svh */
// register offsets, field positions, reset values and codes for the hub pin control block
`ifndef HGP_DEFINES_SVH
`define HGP_DEFINES_SVH
`define HGP_OFS_RX_PORT_CTL 8'h0c
`define HGP_OFS_IO_LEVEL 8'h0d
`define HGP_OFS_PIN_STS 8'h0e
`define HGP_OFS_INPUT_EN 8'h0f
`define HGP_OFS_PIN0_CTL 8'h10
`define HGP_RST_RX_PORT_CTL 8'h0f
`define HGP_RST_IO_LEVEL 8'h09
`define HGP_RST_INPUT_EN 8'hff
`define HGP_RST_PIN0_CTL 8'h00
`define HGP_BIT_CH1_MAP 5
`define HGP_BIT_CH0_MAP 4
`define HGP_BIT_SEL3P3 7
`define HGP_BIT_OVR 6
`define HGP_SRC_STATUS 3'h4
`define HGP_MODE_3P3 2'h3
`define HGP_MODE_1P8 2'h0
`endif

/* pkg/hgp_pkg.sv */
// types shared by the hub pin control block
package hgp_pkg;
  typedef enum logic [1:0] {
    HGP_IDLE = 2'b00,
    HGP_DATA = 2'b01
  } hgp_phase_e;
  typedef struct packed {
    hgp_phase_e phase;
    logic wr;
    logic [7:0] idx;
  } hgp_ahb_s;
endpackage

/* hw/hgp_sync.sv */
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
module hgp_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  // first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule

/* hw/hgp_mux.sv */
// pin 0 output source and select multiplexer
`timescale 1ns/10ps
`include "hgp_defines.svh"
module hgp_mux (
  // control
  input wire logic [2:0] src,
  input wire logic [2:0] sel,
  input wire logic out_val,
  // input port status
  input wire logic [15:0] rx_rem,
  input wire logic [3:0] rx_lock,
  input wire logic [3:0] rx_pass,
  input wire logic [3:0] rx_fv,
  input wire logic [3:0] rx_lv,
  input wire logic [3:0] rx_on,
  input wire logic frame_sync_signal,
  // transmit port status
  input wire logic [1:0] tx_pass_and,
  input wire logic [1:0] tx_pass_or,
  input wire logic [1:0] tx_fv,
  input wire logic [1:0] tx_lv,
  input wire logic [1:0] tx_synced,
  input wire logic [1:0] tx_irq,
  // result
  output logic y
);
  logic [1:0] p;
  logic t;
  // binary port index from the source, then the select; reserved codes give low
  always_comb begin
    p = src[1:0];
    t = src[0];
    y = 1'b0;
    if (!src[2]) begin
      unique case (sel)
        3'h0, 3'h1, 3'h2, 3'h3: y = rx_rem[{p, sel[1:0]}];
        3'h4: y = rx_lock[p];
        3'h5: y = rx_pass[p];
        3'h6: y = rx_fv[p];
        default: y = rx_lv[p];
      endcase
    end else if (src == `HGP_SRC_STATUS) begin
      unique case (sel)
        3'h0: y = out_val;
        3'h1: y = |(rx_lock & rx_on);
        3'h2: y = &(rx_lock | ~rx_on);
        3'h3: y = &(rx_pass | ~rx_on);
        3'h4: y = frame_sync_signal;
        default: y = 1'b0;
      endcase
    end else if (src[1]) begin
      unique case (sel)
        3'h0: y = tx_pass_and[t];
        3'h1: y = tx_pass_or[t];
        3'h2: y = tx_fv[t];
        3'h3: y = tx_lv[t];
        3'h4: y = tx_synced[t];
        3'h5: y = tx_irq[t];
        default: y = 1'b0;
      endcase
    end
  end
endmodule

/* hw/hgp_top.sv */
// hub pin control: ahb-lite registers, level select, pin status and pin 0 output
`timescale 1ns/10ps
`include "hgp_defines.svh"
module hgp_top
  import hgp_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // supply detect pin, asynchronous
  input wire logic detected_3p3,
  // general-purpose pins
  input wire logic [7:0] pin_in,
  output logic pin0_out,
  output logic pin0_oe,
  // remote status, asynchronous to hclk
  input wire logic [15:0] rx_rem,
  input wire logic [3:0] rx_lock,
  input wire logic [3:0] rx_pass,
  input wire logic [3:0] rx_fv,
  input wire logic [3:0] rx_lv,
  input wire logic frame_sync_signal,
  input wire logic [1:0] tx_pass_and,
  input wire logic [1:0] tx_pass_or,
  input wire logic [1:0] tx_fv,
  input wire logic [1:0] tx_lv,
  input wire logic [1:0] tx_synced,
  input wire logic [1:0] tx_irq,
  // control outputs
  output logic chan1_target_port_sel,
  output logic chan0_target_port_sel,
  output logic [3:0] input_port_rx_on,
  output logic high_voltage_level_select,
  output logic [1:0] io_supply_mode
);
  typedef struct packed {
    hgp_ahb_s ap;
    logic [7:0] rx_ctl;
    logic [7:0] io_lvl;
    logic [7:0] in_en;
    logic [7:0] p0_ctl;
    logic [31:0] rdata;
    logic pin0;
    logic oe;
    logic sel3;
    logic [1:0] mode;
  } hgp_state_s;

  hgp_state_s st_q, st_d;
  logic [7:0] pins_s;
  logic det_s;
  logic [44:0] stat_s;
  logic mux_y;
  logic [7:0] pin_levels;
  logic [7:0] io_rd;

  // all asynchronous inputs pass two flops before use
  hgp_sync #(.W(8)) u_sync_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pin_in),
    .q(pins_s)
  );
  hgp_sync #(.W(1)) u_sync_det (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(detected_3p3),
    .q(det_s)
  );
  hgp_sync #(.W(45)) u_sync_stat (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({rx_rem, rx_lock, rx_pass, rx_fv, rx_lv, frame_sync_signal,
        tx_pass_and, tx_pass_or, tx_fv, tx_lv, tx_synced, tx_irq}),
    .q(stat_s)
  );

  // pin 0 output selection
  hgp_mux u_mux (
    .src(st_q.p0_ctl[4:2]),
    .sel(st_q.p0_ctl[7:5]),
    .out_val(st_q.p0_ctl[1]),
    .rx_rem(stat_s[44:29]),
    .rx_lock(stat_s[28:25]),
    .rx_pass(stat_s[24:21]),
    .rx_fv(stat_s[20:17]),
    .rx_lv(stat_s[16:13]),
    .rx_on(st_q.rx_ctl[3:0]),
    .frame_sync_signal(stat_s[12]),
    .tx_pass_and(stat_s[11:10]),
    .tx_pass_or(stat_s[9:8]),
    .tx_fv(stat_s[7:6]),
    .tx_lv(stat_s[5:4]),
    .tx_synced(stat_s[3:2]),
    .tx_irq(stat_s[1:0]),
    .y(mux_y)
  );

  // disabled input paths read as low
  assign pin_levels = pins_s & st_q.in_en;

  // without override the level fields read back the detected supply
  always_comb begin
    io_rd = st_q.io_lvl;
    if (!st_q.io_lvl[`HGP_BIT_OVR]) begin
      io_rd[`HGP_BIT_SEL3P3] = det_s;
      io_rd[5:4] = det_s ? `HGP_MODE_3P3 : `HGP_MODE_1P8;
    end
  end

  // next state: bus phases, register writes, read data, outputs
  always_comb begin
    st_d = st_q;
    // data phase of a write lands in the addressed register
    if (st_q.ap.phase == HGP_DATA && st_q.ap.wr) begin
      unique case (st_q.ap.idx)
        `HGP_OFS_RX_PORT_CTL: st_d.rx_ctl = hwdata[7:0];
        `HGP_OFS_IO_LEVEL: st_d.io_lvl = hwdata[7:0];
        `HGP_OFS_INPUT_EN: st_d.in_en = hwdata[7:0];
        `HGP_OFS_PIN0_CTL: st_d.p0_ctl = hwdata[7:0];
        default: ;
      endcase
    end
    // address phase; read data prepared for the next cycle
    st_d.ap.phase = HGP_IDLE;
    st_d.ap.wr = 1'b0;
    st_d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1]) begin
      st_d.ap.phase = HGP_DATA;
      st_d.ap.wr = hwrite;
      // out-of-range addresses map to an unused index so writes are dropped
      st_d.ap.idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'hff;
      if (!hwrite && haddr[31:10] == 22'h0) begin
        unique case (haddr[9:2])
          `HGP_OFS_RX_PORT_CTL: st_d.rdata = {24'h00_0000, st_q.rx_ctl};
          `HGP_OFS_IO_LEVEL: st_d.rdata = {24'h00_0000, io_rd};
          `HGP_OFS_PIN_STS: st_d.rdata = {24'h00_0000, pin_levels};
          `HGP_OFS_INPUT_EN: st_d.rdata = {24'h00_0000, st_q.in_en};
          `HGP_OFS_PIN0_CTL: st_d.rdata = {24'h00_0000, st_q.p0_ctl};
          default: st_d.rdata = 32'h0000_0000;
        endcase
      end
    end
    // supply controls: override picks the written fields
    if (st_q.io_lvl[`HGP_BIT_OVR]) begin
      st_d.sel3 = st_q.io_lvl[`HGP_BIT_SEL3P3];
      st_d.mode = st_q.io_lvl[5:4];
    end else begin
      st_d.sel3 = det_s;
      st_d.mode = det_s ? `HGP_MODE_3P3 : `HGP_MODE_1P8;
    end
    // driver active only while enable bit is set
    st_d.oe = st_q.p0_ctl[0];
    st_d.pin0 = st_q.p0_ctl[0] & mux_y;
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q.ap <= '{phase: HGP_IDLE, wr: 1'b0, idx: 8'h00};
      st_q.rx_ctl <= `HGP_RST_RX_PORT_CTL;
      st_q.io_lvl <= `HGP_RST_IO_LEVEL;
      st_q.in_en <= `HGP_RST_INPUT_EN;
      st_q.p0_ctl <= `HGP_RST_PIN0_CTL;
      st_q.rdata <= 32'h0000_0000;
      st_q.pin0 <= 1'b0;
      st_q.oe <= 1'b0;
      st_q.sel3 <= 1'b0;
      st_q.mode <= 2'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops; slave never stalls, always okay
  assign hrdata = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign chan1_target_port_sel = st_q.rx_ctl[`HGP_BIT_CH1_MAP];
  assign chan0_target_port_sel = st_q.rx_ctl[`HGP_BIT_CH0_MAP];
  assign input_port_rx_on = st_q.rx_ctl[3:0];
  assign high_voltage_level_select = st_q.sel3;
  assign io_supply_mode = st_q.mode;
  assign pin0_out = st_q.pin0;
  assign pin0_oe = st_q.oe;
endmodule

/* bench/hgp_assertions.sv */
// checker for the hub pin control block, bound to its top
`timescale 1ns/10ps
module hgp_assertions (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and controls
  input wire logic detected_3p3,
  input wire logic pin0_out,
  input wire logic pin0_oe,
  input wire logic chan1_target_port_sel,
  input wire logic chan0_target_port_sel,
  input wire logic [3:0] input_port_rx_on,
  input wire logic high_voltage_level_select,
  input wire logic [1:0] io_supply_mode
);
  logic wr_q, rd_q, aw_q, ovr_q;
  wire logic req = hsel && hready && htrans[1];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // data-phase flags and a copy of the override bit, so rules can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_q, rd_q, aw_q, ovr_q} <= 4'h0;
    end else begin
      wr_q <= req && hwrite;
      rd_q <= req && !hwrite;
      aw_q <= req && hwrite && haddr[7:0] == 8'h34;
      if (aw_q) begin
        ovr_q <= hwdata[6];
      end
    end
  end
  // the supply level has been quiet with override off long enough to settle
  sequence s_quiet_level;
    (!ovr_q && $stable(detected_3p3)) [*6];
  endsequence
  a_out_gated: assert property (!pin0_oe |-> !pin0_out)
    else $error("pin0 level while not driving");
  a_map_hold: assert property (!wr_q && !$past(wr_q) |=>
    $stable({chan1_target_port_sel, chan0_target_port_sel, input_port_rx_on}))
    else $error("map or rx enable moved without write");
  a_oe_hold: assert property (!wr_q |-> ##2 $stable(pin0_oe))
    else $error("pin0 enable moved without write");
  a_rst_vals: assert property ($rose(hresetn) |-> input_port_rx_on == 4'hf
    && !chan1_target_port_sel && !chan0_target_port_sel && !pin0_oe)
    else $error("bad reset values");
  a_level_follow: assert property (s_quiet_level |->
    high_voltage_level_select == detected_3p3 && io_supply_mode == {2{detected_3p3}})
    else $error("level not following detect");
  a_mode_pair: assert property (!ovr_q [*3] |-> io_supply_mode[1] == io_supply_mode[0])
    else $error("supply mode not 00 or 11");
  a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
endmodule
bind hgp_top hgp_assertions hgp_assertions_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hwdata, .hrdata, .hreadyout, .hresp, .detected_3p3, .pin0_out, .pin0_oe,
  .chan1_target_port_sel, .chan0_target_port_sel, .input_port_rx_on,
  .high_voltage_level_select, .io_supply_mode);

/* bench/hgp_board_model.sv */
// board-side model: pin, supply and remote status levels
`timescale 1ns/10ps
module hgp_board_model (
  // clock
  input wire logic hclk,
  // requested and present levels
  input wire logic [53:0] stim,
  output logic [53:0] pins
);
  // levels move just after an edge, settling within that edge's time step, one clock after the request
  always_ff @(posedge hclk) begin
    pins <= stim;
  end
endmodule

/* bench/tb_hub_gpio_and_port_control.sv */
// testbench for the hub pin control block
`timescale 1ns/10ps
module tb_hub_gpio_and_port_control;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [53:0] stim = '0;
  logic [53:0] bp;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin0_out, pin0_oe, high_voltage_level_select;
  logic chan1_target_port_sel, chan0_target_port_sel;
  logic [3:0] input_port_rx_on;
  logic [1:0] io_supply_mode;
  wire logic hready = hreadyout;
  int error_cnt = 0;
  int check_count = 0;
  // det, pins, tx irq/sync/lv/fv/or/and, frame sync, rx lv/fv/pass/lock, remote pins
  localparam logic [53:0] pat = {1'b0, 8'ha5, 12'h5a6, 1'b1, 4'h6, 4'h9, 4'hf, 4'h7, 16'ha5c3};
  hgp_board_model hgp_board_model_i (.hclk, .stim, .pins(bp));
  hgp_top hgp_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .detected_3p3(bp[53]), .pin_in(bp[52:45]),
    .pin0_out, .pin0_oe, .rx_rem(bp[15:0]), .rx_lock(bp[19:16]), .rx_pass(bp[23:20]),
    .rx_fv(bp[27:24]), .rx_lv(bp[31:28]), .frame_sync_signal(bp[32]),
    .tx_pass_and(bp[34:33]), .tx_pass_or(bp[36:35]), .tx_fv(bp[38:37]), .tx_lv(bp[40:39]),
    .tx_synced(bp[42:41]), .tx_irq(bp[44:43]), .chan1_target_port_sel,
    .chan0_target_port_sel, .input_port_rx_on, .high_voltage_level_select, .io_supply_mode);
  // free-running bus clock
  always #4 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single transfer; waits on hready, never on a cycle count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0000_00, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0000_00, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    xfer(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask
  // expected pin 0 level; all receivers stay enabled while it is used
  function automatic logic ex(input logic [53:0] s, input logic [2:0] src, input logic [2:0] sel,
    input logic v);
    case (src)
      3'h4: case (sel)
        3'h0: return v;
        3'h1: return |s[19:16];
        3'h2: return &s[19:16];
        3'h3: return &s[23:20];
        3'h4: return s[32];
        default: return 1'b0;
      endcase
      3'h5: return 1'b0;
      3'h6, 3'h7: return sel < 3'h6 ? s[33 + int'({sel, src[0]})] : 1'b0;
      default: return sel < 3'h4 ? s[{src[1:0], sel[1:0]}] : s[{2'h1, sel[1:0], src[1:0]}];
    endcase
  endfunction
  task automatic t_reset;
    rd(8'h30, 8'h0f);
    rd(8'h3c, 8'hff);
    rd(8'h40, 8'h00);
    rd(8'h34, 8'h09);
  endtask
  task automatic t_map;
    wr(8'h30, 8'hf5);
    repeat (2) @(posedge hclk);
    chk({chan1_target_port_sel, chan0_target_port_sel, input_port_rx_on}, 6'h35);
    rd(8'h30, 8'hf5);
    wr(8'h30, 8'h0f);
  endtask
  task automatic t_level;
    stim[53] <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(8'h34, 8'hb9);
    wr(8'h34, 8'h49);
    rd(8'h34, 8'h49);
    stim[53] <= 1'b0;
    wr(8'h34, 8'hf9);
    repeat (8) @(posedge hclk);
    rd(8'h34, 8'hf9);
    chk({high_voltage_level_select, io_supply_mode}, 3'h7);
    wr(8'h34, 8'h09);
    repeat (8) @(posedge hclk);
    rd(8'h34, 8'h09);
  endtask
  // disabled inputs read low; status ignores writes; unmapped reads zero
  task automatic t_status;
    stim[52:45] <= 8'ha5;
    wr(8'h3c, 8'h0f);
    repeat (6) @(posedge hclk);
    rd(8'h38, 8'h05);
    wr(8'h38, 8'hff);
    rd(8'h38, 8'h05);
    rd(8'h7c, 8'h00);
    wr(8'h3c, 8'hff);
    repeat (2) @(posedge hclk);
    rd(8'h38, 8'ha5);
  endtask
  // every source and select code, against a pattern and its inverse
  task automatic t_mux;
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 64; c++) begin
        stim <= k[0] ? ~pat : pat;
        wr(8'h40, {c[5:3], c[2:0], k[0], 1'b1});
        repeat (6) @(posedge hclk);
        chk({pin0_oe, pin0_out}, {1'b1, ex(k[0] ? ~pat : pat, c[2:0], c[5:3], k[0])});
      end
    end
    wr(8'h40, 8'h12);
    repeat (3) @(posedge hclk);
    chk({pin0_oe, pin0_out}, 2'h0);
  endtask
  task automatic summarize;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_map;
    t_level;
    t_status;
    t_mux;
    summarize;
  end
  // watchdog: the run needs about 1100 cycles, so 100 us means a hang
  initial begin
    #100000;
    error_cnt++;
    summarize;
  end
endmodule
